// ---- common/hpd_pkg.sv ----
// shared constants and types for the host port pin direction block
`default_nettype none
package hpd_pkg;
  localparam int unsigned HPD_DATA_W     = 8;   // host data lines
  localparam int unsigned HPD_SEL_W      = 3;   // register select inputs
  localparam int unsigned HPD_GPIO_W     = 12;  // shared pins: data, select, read/write
  localparam int unsigned HPD_FIFO_DEPTH = 8;   // incoming byte buffer depth
  localparam int unsigned HPD_FIFO_W     = HPD_SEL_W + HPD_DATA_W; // select + byte
  // field positions inside the shared pin vector
  localparam int unsigned HPD_GP_DATA_LSB = 0;
  localparam int unsigned HPD_GP_SEL_LSB  = 8;
  localparam int unsigned HPD_GP_RW_BIT   = 11;
  // values after reset
  localparam logic [HPD_DATA_W-1:0] HPD_DATA_RST = 8'h00;
  localparam logic [HPD_SEL_W-1:0]  HPD_SEL_RST  = 3'h0;
  localparam logic [HPD_GPIO_W-1:0] HPD_GPIO_RST = 12'h000; // all inputs
  // access sequencer states
  typedef enum logic [1:0] {
    HPD_IDLE,
    HPD_READ,
    HPD_WRITE
  } hpd_state_e;
endpackage
`default_nettype wire

// ---- hw/hpd_host_port.sv ----
// host port pin steering, strobe sequencer and incoming byte buffer
`timescale 1ns/1ps
`default_nettype none

// small synchronous fifo with valid/ready on both sides
module hpd_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];  // storage array
  logic [AW:0]      wr_q, wr_d;     // write pointer with wrap bit
  logic [AW:0]      rd_q, rd_d;     // read pointer with wrap bit
  logic             push, pop;
  logic             full, empty;

  // full when pointers differ only in the wrap bit
  always_comb begin
    empty = (wr_q == rd_q);
    full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    push  = in_valid_i && !full;
    pop   = !empty && out_ready_i;  // from the pointers, not the output port
    wr_d  = push ? ((wr_q[AW-1:0] == AW'(DEPTH-1)) ? {~wr_q[AW], {AW{1'b0}}} : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q[AW-1:0] == AW'(DEPTH-1)) ? {~rd_q[AW], {AW{1'b0}}} : rd_q + 1'b1) : rd_q;
  end

  // pointers only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset; contents are guarded by the pointers
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
endmodule

module hpd_host_port
  import hpd_pkg::*;
#(
  parameter int unsigned DATA_W     = HPD_DATA_W,
  parameter int unsigned FIFO_DEPTH = HPD_FIFO_DEPTH
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // device-side control
  input  wire logic                  host_port_en_i,      // host function selected
  input  wire logic                  service_want_i,      // device wants service
  input  wire logic [DATA_W-1:0]     tx_data_i,           // outgoing byte for the host
  input  wire logic [HPD_GPIO_W-1:0] gpio_out_i,          // general-purpose out values
  input  wire logic [HPD_GPIO_W-1:0] gpio_dir_i,          // 1 = drive pin
  output logic      [HPD_GPIO_W-1:0] gpio_in_o,           // sampled pin levels
  output logic                       rd_pulse_o,          // host read started
  output logic      [HPD_SEL_W-1:0]  rd_sel_o,            // register being read
  output logic                       rx_valid_o,          // incoming byte ready
  input  wire logic                  rx_ready_i,          // device takes byte
  output logic      [HPD_SEL_W-1:0]  rx_sel_o,            // register written
  output logic      [DATA_W-1:0]     rx_data_o,           // host byte
  output logic                       wr_busy_o,           // captured byte not yet pushed into the buffer
  // shared pins, three signals each
  input  wire logic [DATA_W-1:0]     host_data_lines_i,
  output logic      [DATA_W-1:0]     host_data_lines_o,
  output logic      [DATA_W-1:0]     host_data_lines_oe_o,
  input  wire logic [HPD_SEL_W-1:0]  register_select_i,
  output logic      [HPD_SEL_W-1:0]  register_select_o,
  output logic      [HPD_SEL_W-1:0]  register_select_oe_o,
  input  wire logic                  read_write_select_i,
  output logic                       read_write_select_o,
  output logic                       read_write_select_oe_o,
  // host-only pins
  input  wire logic                  transfer_strobe_n_i,
  input  wire logic                  acknowledge_in_n_i,
  output logic                       service_request_n_o,
  output logic                       service_request_n_oe_o
);
  localparam int unsigned SW = DATA_W + HPD_SEL_W + 3; // synchronised pin count

  // two-stage synchronisers for every asynchronous pin
  logic [SW-1:0] meta_q;     // first stage, read only by sync_q
  logic [SW-1:0] sync_q;     // second stage, usable by logic
  logic [DATA_W-1:0]    data_s;
  logic [HPD_SEL_W-1:0] sel_s;
  logic                 rw_s, strobe_n_s, ack_n_s;

  // sequencer and capture state
  hpd_state_e        st_q, st_d;
  logic [HPD_SEL_W-1:0] acc_sel_q, acc_sel_d;   // select held for the access
  logic              rd_pulse_q, rd_pulse_d;
  logic              pend_q, pend_d;            // captured byte awaiting push
  logic [HPD_FIFO_W-1:0] pend_word_q, pend_word_d;

  // pin drive state
  logic [DATA_W-1:0]    dout_q, dout_d;
  logic [DATA_W-1:0]    doe_q, doe_d;
  logic [HPD_SEL_W-1:0] sout_q, sout_d, soe_q, soe_d;
  logic                 rwout_q, rwout_d, rwoe_q, rwoe_d;
  logic                 srq_q, srq_d;           // pulling service request low
  logic                 en_q;                   // host function, registered

  // buffer hookup
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [HPD_FIFO_W-1:0] fifo_out_data;
  logic                  drive_host;

  // pin sampling; same latency for data, strobe and direction
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {SW{1'b1}};
      sync_q <= {SW{1'b1}};
    end else begin
      meta_q <= {acknowledge_in_n_i, transfer_strobe_n_i, read_write_select_i,
                 register_select_i, host_data_lines_i};
      sync_q <= meta_q;
    end
  end

  // unpack synchronised levels
  always_comb begin
    data_s     = sync_q[DATA_W-1:0];
    sel_s      = sync_q[DATA_W +: HPD_SEL_W];
    rw_s       = sync_q[DATA_W+HPD_SEL_W];
    strobe_n_s = sync_q[DATA_W+HPD_SEL_W+1];
    ack_n_s    = sync_q[DATA_W+HPD_SEL_W+2];
  end

  // access sequencer: one transfer per strobe low period
  always_comb begin
    st_d        = st_q;
    acc_sel_d   = acc_sel_q;
    rd_pulse_d  = 1'b0;
    pend_d      = pend_q;
    pend_word_d = pend_word_q;
    // buffer took the waiting byte
    if (pend_q && fifo_in_ready) begin
      pend_d = 1'b0;
    end
    unique case (st_q)
      HPD_IDLE: begin
        // strobe fall seen; direction and select frozen here
        if (en_q && !strobe_n_s) begin
          acc_sel_d = sel_s;
          if (rw_s) begin
            st_d       = HPD_READ;
            rd_pulse_d = 1'b1;
          end else begin
            st_d = HPD_WRITE;
          end
        end
      end
      HPD_READ: begin
        // wait for strobe release, nothing to store
        if (strobe_n_s) begin
          st_d = HPD_IDLE;
        end
      end
      HPD_WRITE: begin
        // byte taken on the rising strobe edge; set beats clear
        if (strobe_n_s) begin
          st_d        = HPD_IDLE;
          pend_d      = 1'b1;
          pend_word_d = {acc_sel_q, data_s};
        end
      end
      // the fourth code of the state word is never entered; recover to idle
      default: begin
        st_d = HPD_IDLE;
      end
    endcase
    // leaving host mode abandons any open access
    if (!en_q) begin
      st_d = HPD_IDLE;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= HPD_IDLE;
      acc_sel_q   <= HPD_SEL_RST;
      rd_pulse_q  <= 1'b0;
      pend_q      <= 1'b0;
      pend_word_q <= '0;
    end else begin
      st_q        <= st_d;
      acc_sel_q   <= acc_sel_d;
      rd_pulse_q  <= rd_pulse_d;
      pend_q      <= pend_d;
      pend_word_q <= pend_word_d;
    end
  end

  // pin direction and values
  always_comb begin
    // drive for a read, or for an acknowledged service request
    drive_host = (!strobe_n_s && rw_s) || (srq_q && !ack_n_s);
    srq_d      = en_q && service_want_i;
    if (en_q) begin
      // strobe high and no acknowledge leaves the lines floating
      doe_d   = drive_host ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
      dout_d  = tx_data_i;
      soe_d   = '0;
      sout_d  = '0;
      rwoe_d  = 1'b0;
      rwout_d = 1'b0;
    end else begin
      // general-purpose pins follow the device's direction bits
      doe_d   = gpio_dir_i[HPD_GP_DATA_LSB +: DATA_W];
      dout_d  = gpio_out_i[HPD_GP_DATA_LSB +: DATA_W];
      soe_d   = gpio_dir_i[HPD_GP_SEL_LSB +: HPD_SEL_W];
      sout_d  = gpio_out_i[HPD_GP_SEL_LSB +: HPD_SEL_W];
      rwoe_d  = gpio_dir_i[HPD_GP_RW_BIT];
      rwout_d = gpio_out_i[HPD_GP_RW_BIT];
    end
  end

  // pin registers; reset floats everything and leaves gpio inputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q    <= 1'b0;
      doe_q   <= HPD_GPIO_RST[HPD_GP_DATA_LSB +: DATA_W];
      dout_q  <= HPD_DATA_RST;
      soe_q   <= HPD_GPIO_RST[HPD_GP_SEL_LSB +: HPD_SEL_W];
      sout_q  <= HPD_SEL_RST;
      rwoe_q  <= HPD_GPIO_RST[HPD_GP_RW_BIT];
      rwout_q <= 1'b0;
      srq_q   <= 1'b0;
    end else begin
      en_q    <= host_port_en_i;
      doe_q   <= doe_d;
      dout_q  <= dout_d;
      soe_q   <= soe_d;
      sout_q  <= sout_d;
      rwoe_q  <= rwoe_d;
      rwout_q <= rwout_d;
      srq_q   <= srq_d;
    end
  end

  // buffer between host writes and the device; full stalls via wr_busy_o
  hpd_fifo #(
    .WIDTH (HPD_FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (pend_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_word_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rx_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // outgoing ports; fifo head is its own storage, read combinationally
  assign host_data_lines_o      = dout_q;
  assign host_data_lines_oe_o   = doe_q;
  assign register_select_o      = sout_q;
  assign register_select_oe_o   = soe_q;
  assign read_write_select_o    = rwout_q;
  assign read_write_select_oe_o = rwoe_q;
  assign service_request_n_o    = 1'b0;   // open drain: only ever pulls low
  assign service_request_n_oe_o = srq_q;
  assign gpio_in_o              = sync_q[HPD_GPIO_W-1:0];
  assign rd_pulse_o             = rd_pulse_q;
  assign rd_sel_o               = acc_sel_q;
  assign wr_busy_o              = pend_q;
  assign rx_valid_o             = fifo_out_valid;
  assign rx_sel_o               = fifo_out_data[HPD_FIFO_W-1 -: HPD_SEL_W];
  assign rx_data_o              = fifo_out_data[DATA_W-1:0];
endmodule
`default_nettype wire

// ---- sim/hpd_host_port_chk.sv ----
// timing checker for the host port pin steering block
`timescale 1ns/1ps
`default_nettype none
module hpd_host_port_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        host_port_en_i,
  input wire logic        service_want_i,
  input wire logic [11:0] gpio_dir_i,
  input wire logic        rd_pulse_o,
  input wire logic [2:0]  rd_sel_o,
  input wire logic        rx_valid_o,
  input wire logic        wr_busy_o,
  input wire logic [7:0]  host_data_lines_oe_o,
  input wire logic [2:0]  register_select_i,
  input wire logic [2:0]  register_select_oe_o,
  input wire logic        read_write_select_i,
  input wire logic        read_write_select_oe_o,
  input wire logic        transfer_strobe_n_i,
  input wire logic        acknowledge_in_n_i,
  input wire logic        service_request_n_o,
  input wire logic        service_request_n_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // read access opens: strobe falls with read selected
  sequence s_rd_fall;
    host_port_en_i && read_write_select_i && $fell(transfer_strobe_n_i);
  endsequence
  // access closes: strobe rises, no acknowledge pending
  sequence s_end(logic rw);
    host_port_en_i && acknowledge_in_n_i && read_write_select_i == rw && $rose(transfer_strobe_n_i);
  endsequence
  a_read_pulse: assert property (
    s_rd_fall |-> ##3 (rd_pulse_o && host_data_lines_oe_o == 8'hFF) ##1 !rd_pulse_o)
    else $error("read did not start on time");
  a_read_sel: assert property (s_rd_fall |-> ##3 rd_sel_o == $past(register_select_i, 3))
    else $error("read select not latched");
  a_read_release: assert property (
    s_end(1'b1) |-> ##2 host_data_lines_oe_o == 8'hFF ##1 host_data_lines_oe_o == 8'h00)
    else $error("data lines not released after read");
  a_write_push: assert property (s_end(1'b0) |-> ##3 wr_busy_o ##1 rx_valid_o)
    else $error("write byte not taken");
  a_write_input: assert property (
    (host_port_en_i && !read_write_select_i && !transfer_strobe_n_i && acknowledge_in_n_i)[*5]
    |-> host_data_lines_oe_o == 8'h00) else $error("data driven during write");
  a_idle_float: assert property (
    (host_port_en_i && transfer_strobe_n_i && acknowledge_in_n_i)[*5]
    |-> host_data_lines_oe_o == 8'h00) else $error("data driven while idle");
  a_sreq_drive: assert property (
    (service_want_i && host_port_en_i)[*4] |-> service_request_n_oe_o && !service_request_n_o)
    else $error("service request not pulled low");
  a_sreq_idle: assert property ((!service_want_i)[*4] |-> !service_request_n_oe_o)
    else $error("service request stuck");
  a_ack_drive: assert property (
    service_request_n_oe_o && $fell(acknowledge_in_n_i) |-> ##3 host_data_lines_oe_o == 8'hFF)
    else $error("acknowledge did not drive data");
  a_gpio_dir: assert property ((!host_port_en_i)[*3] |->
    {read_write_select_oe_o, register_select_oe_o, host_data_lines_oe_o} == $past(gpio_dir_i))
    else $error("general purpose direction wrong");
  a_host_sel_in: assert property (
    host_port_en_i[*3] |-> register_select_oe_o == 3'h0 && !read_write_select_oe_o)
    else $error("select pins driven in host mode");
endmodule
bind hpd_host_port hpd_host_port_chk chk_u (.core_clk_i, .rst_n_i, .host_port_en_i, .service_want_i, .gpio_dir_i,
  .rd_pulse_o, .rd_sel_o, .rx_valid_o, .wr_busy_o, .host_data_lines_oe_o, .register_select_i, .register_select_oe_o,
  .read_write_select_i, .read_write_select_oe_o, .transfer_strobe_n_i, .acknowledge_in_n_i, .service_request_n_o,
  .service_request_n_oe_o);
`default_nettype wire

// ---- sim/hpd_host_model.sv ----
// behavioural host processor driving the host port pins
`timescale 1ns/1ps
`default_nettype none
module hpd_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,     // resolved data wire
  output logic            strobe_n_o, // transfer strobe
  output logic            ack_n_o,    // acknowledge
  output logic            rw_o,       // 1 = read
  output logic      [2:0] sel_o,      // register select
  output logic      [7:0] data_o,     // write byte
  output logic            data_en_o   // host drives data
);
  // idle host: nothing asserted, bus released
  initial begin
    strobe_n_o = 1'b1;
    ack_n_o = 1'b1;
    rw_o = 1'b1;
    sel_o = 3'h0;
    data_o = 8'h00;
    data_en_o = 1'b0;
  end
  // one strobe access; low sets how slowly the host answers
  task automatic xfer(input logic rw, input logic [2:0] sel, input logic [7:0] d, input int low, output logic [7:0] q);
    @(negedge clk_i);
    rw_o = rw;
    sel_o = sel;
    data_o = d;
    data_en_o = !rw;
    strobe_n_o = 1'b0;
    repeat (low) @(negedge clk_i);
    q = data_i;
    strobe_n_o = 1'b1;
    // byte held past the rise so the resynchronised edge still sees it
    repeat (5) @(negedge clk_i);
    data_en_o = 1'b0;
    sel_o = ~sel;
  endtask
  // dma handshake answering the service request
  task automatic dma(input int low, output logic [7:0] q);
    @(negedge clk_i);
    ack_n_o = 1'b0;
    repeat (low) @(negedge clk_i);
    q = data_i;
    ack_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- sim/hpd_host_port_tb_top.sv ----
// self-checking bench for the host port pin steering block
`timescale 1ns/1ps
`default_nettype none
`define HPD_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module hpd_host_port_tb_top;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, host_port_en_i = 1'b0, service_want_i = 1'b0, rx_ready_i = 1'b0;
  logic [7:0]  tx_data_i = 8'h00, host_data_lines_i, host_data_lines_o, host_data_lines_oe_o, rx_data_o, h_d;
  logic [7:0]  d_last = 8'h00;
  logic [11:0] gpio_out_i = 12'h000, gpio_dir_i = 12'h000, gpio_in_o;
  logic [2:0]  register_select_i, register_select_o, register_select_oe_o, rx_sel_o, h_sel;
  logic        read_write_select_i, read_write_select_o, read_write_select_oe_o, h_rw, h_den, h_ack;
  logic        transfer_strobe_n_i, rx_valid_o, wr_busy_o, service_request_n_o, service_request_n_oe_o;
  logic [10:0] exp_q[$];  // writes not yet popped
  logic [10:0] exp_w;     // oldest write, taken once per pop
  int          mismatches = 0, checks_done = 0, rmode = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  // wire levels; released data shows the inverse of its last level
  assign host_data_lines_i = (host_data_lines_oe_o & host_data_lines_o)
                           | (~host_data_lines_oe_o & (h_den ? h_d : ~d_last));
  assign register_select_i = (register_select_oe_o & register_select_o) | (~register_select_oe_o & h_sel);
  assign read_write_select_i = read_write_select_oe_o ? read_write_select_o : h_rw;
  always @(posedge core_clk_i) d_last <= host_data_lines_i;
  // far side stalls at random, holds off or takes everything
  always @(negedge core_clk_i) rx_ready_i <= (rmode == 2) || (rmode == 1 && $urandom % 2);
  // every popped byte must be the oldest write
  // pop into a variable first so a mismatch report cannot pop a second time
  always @(posedge core_clk_i) begin
    if (rst_n_i && rx_valid_o && rx_ready_i) begin
      exp_w = exp_q.pop_front();
      `HPD_CHK({rx_sel_o, rx_data_o}, exp_w)
    end
  end
  hpd_host_port dut_u (.core_clk_i, .rst_n_i, .host_port_en_i, .service_want_i, .tx_data_i, .gpio_out_i, .gpio_dir_i,
    .gpio_in_o, .rd_pulse_o(), .rd_sel_o(), .rx_valid_o, .rx_ready_i, .rx_sel_o, .rx_data_o, .wr_busy_o,
    .host_data_lines_i, .host_data_lines_o, .host_data_lines_oe_o, .register_select_i, .register_select_o,
    .register_select_oe_o, .read_write_select_i, .read_write_select_o, .read_write_select_oe_o, .transfer_strobe_n_i,
    .acknowledge_in_n_i(h_ack), .service_request_n_o, .service_request_n_oe_o);
  hpd_host_model host_u (.clk_i(core_clk_i), .data_i(host_data_lines_i), .strobe_n_o(transfer_strobe_n_i),
    .ack_n_o(h_ack), .rw_o(h_rw), .sel_o(h_sel), .data_o(h_d), .data_en_o(h_den));
  function automatic logic [10:0] rx_word(input logic [2:0] s, input logic [7:0] d);
    return {s, d};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    logic [7:0] q, d;
    logic [2:0] s;
    logic       r;
    void'($urandom(33305));
    repeat (3) @(posedge core_clk_i);
    `HPD_CHK({host_data_lines_oe_o, register_select_oe_o}, 11'h000)
    `HPD_CHK({read_write_select_oe_o, service_request_n_oe_o}, 2'h0)
    @(negedge core_clk_i) rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    `HPD_CHK({read_write_select_oe_o, register_select_oe_o, host_data_lines_oe_o}, 12'h000)
    // general purpose mode with random directions
    for (int i = 0; i < 4; i++) begin
      gpio_dir_i = 12'($urandom);
      gpio_out_i = 12'($urandom);
      repeat (5) @(negedge core_clk_i);
      `HPD_CHK({read_write_select_oe_o, register_select_oe_o, host_data_lines_oe_o}, gpio_dir_i)
      `HPD_CHK(gpio_in_o & gpio_dir_i, gpio_out_i & gpio_dir_i)
    end
    // random host accesses, shortest legal strobe among them
    host_port_en_i = 1'b1;
    rmode = 1;
    repeat (4) @(negedge core_clk_i);
    for (int i = 0; i < 12; i++) begin
      r = 1'($urandom);
      s = 3'($urandom);
      d = 8'($urandom);
      tx_data_i = 8'($urandom);
      if (!r) exp_q.push_back(rx_word(s, d));
      host_u.xfer(r, s, d, r ? 5 + $urandom % 4 : 3 + i % 3, q);
      if (r) `HPD_CHK(q, tx_data_i)
    end
    // fill the buffer past its depth while the far side stalls
    rmode = 2;
    repeat (20) @(negedge core_clk_i);
    rmode = 0;
    for (int i = 0; i <= hpd_pkg::HPD_FIFO_DEPTH; i++) begin
      exp_q.push_back(rx_word(i[2:0], 8'hF0 ^ i[7:0]));
      host_u.xfer(1'b0, i[2:0], 8'hF0 ^ i[7:0], 3, q);
    end
    `HPD_CHK({wr_busy_o, rx_valid_o}, 2'h3)
    rmode = 2;
    repeat (20) @(negedge core_clk_i);
    `HPD_CHK({exp_q.size() == 0, rx_valid_o, wr_busy_o}, 3'h4)
    // dma handshake on a service request
    service_want_i = 1'b1;
    tx_data_i = 8'hA5;
    repeat (5) @(negedge core_clk_i);
    `HPD_CHK(service_request_n_oe_o ? service_request_n_o : 1'b1, 1'b0)
    host_u.dma(6, q);
    `HPD_CHK(q, 8'hA5)
    service_want_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    `HPD_CHK({service_request_n_oe_o, host_data_lines_oe_o}, 9'h000)
    // strobe ignored once the host function is off
    host_port_en_i = 1'b0;
    gpio_dir_i = 12'h000;
    host_u.xfer(1'b0, 3'h2, 8'h3C, 4, q);
    `HPD_CHK(rx_valid_o, 1'b0)
    print_verdict;
  end
endmodule
`default_nettype wire
